// ===== design/frc_pkg.sv
// shared constants and carriers of the fault retry controller
package frc_pkg;

  // command code of the response byte and its reset value
  localparam logic [7:0] FRC_CMD_RESPONSE = 8'hc4;
  localparam logic [7:0] FRC_RESPONSE_RST = 8'h00;

  // field positions inside the response byte
  localparam int FRC_MODE_LSB  = 6;
  localparam int FRC_COUNT_LSB = 3;
  localparam int FRC_TIME_LSB  = 0;

  // response modes
  localparam logic [1:0] FRC_MODE_IGNORE  = 2'h0;
  localparam logic [1:0] FRC_MODE_RUN_DLY = 2'h1;
  localparam logic [1:0] FRC_MODE_RETRY   = 2'h2;
  localparam logic [1:0] FRC_MODE_LATCH   = 2'h3;

  // retry counts with a special meaning
  localparam logic [2:0] FRC_COUNT_NONE    = 3'h0;
  localparam logic [2:0] FRC_COUNT_FOREVER = 3'h7;

  // the delay is one unit shifted left by the time field, two raised to it in units
  localparam logic [7:0] FRC_UNIT_ONE = 8'h01;

  typedef enum logic [2:0] {
    FRC_IDLE    = 3'b000,
    FRC_RUN_DLY = 3'b001,
    FRC_WAIT    = 3'b010,
    FRC_TRY     = 3'b011,
    FRC_LATCHED = 3'b100
  } frc_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } frc_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       ack;
    logic [7:0] data;
  } frc_rsp_t;

endpackage

// ===== design/frc_delay_timer.sv
// delay timer counting whole delay units of a programmable length
`timescale 1ns/1ps
`default_nettype none
module frc_delay_timer import frc_pkg::*; #(
  parameter int UNIT_W = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // control
  input  wire logic              load,
  input  wire logic [7:0]        units,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  // result
  output logic                   done_q
);

  logic              run_q, run_d;
  logic [7:0]        unit_q, unit_d;
  logic [UNIT_W-1:0] cyc_q, cyc_d;
  logic              done_d;
  logic [UNIT_W-1:0] cyc_top;

  // a zero unit length is taken as one cycle per unit
  assign cyc_top = (unit_cycles == '0) ? '0 : unit_cycles - 1'b1;

  always_comb begin
    run_d  = run_q;
    unit_d = unit_q;
    cyc_d  = cyc_q;
    done_d = 1'b0;
    if (load) begin
      run_d  = 1'b1;
      unit_d = units - 8'h01;
      cyc_d  = cyc_top;
    end else if (run_q) begin
      if (cyc_q != '0) begin
        cyc_d = cyc_q - 1'b1;
      end else if (unit_q != 8'h00) begin
        unit_d = unit_q - 8'h01;
        cyc_d  = cyc_top;
      end else begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run_q  <= 1'b0;
      unit_q <= 8'h00;
      cyc_q  <= '0;
      done_q <= 1'b0;
    end else begin
      run_q  <= run_d;
      unit_q <= unit_d;
      cyc_q  <= cyc_d;
      done_q <= done_d;
    end
  end

endmodule
`default_nettype wire

// ===== design/frc_fault_retry.sv
// restart policy applied after a fault, configured by one response byte
// Contract
// - retry counts one to six give that many restarts
// - all attempts failed: output off until cleared
// - attempt starts spaced by two power time field units
// - count seven retries forever until off or cleared
// - time field decodes to two power field units
// - run-on delay uses same decoded time
// - unit length comes from separate timing setting
// - mode bits: ignore, run then retry, retry, latch
// - count zero: no restart, off until cleared
// - clear, off-then-on or bias loss clears latch
// - response byte read and written at code 0xc4
`timescale 1ns/1ps
`default_nettype none
module frc_fault_retry import frc_pkg::*; #(
  parameter int UNIT_W = 16
) (
  // clock and reset (reset also stands for loss of bias)
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // decoded management bus command and its answer
  input  wire frc_cmd_t          cmd,
  output frc_rsp_t               rsp_q,
  // fault and control inputs
  input  wire logic              fault_in,
  input  wire logic              clear_fault,
  input  wire logic              output_on_cmd,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  // output control and status
  output logic                   out_enable_q,
  output logic                   restart_q,
  output logic                   latched_q,
  output logic [2:0]             attempts_q
);

  logic [7:0] resp_q, resp_d;
  frc_rsp_t   rsp_d;
  frc_state_t state_q, state_d;
  logic [2:0] attempts_d;
  logic       out_enable_d, restart_d, latched_d;
  logic       tmr_load, tmr_done;
  logic [7:0] tmr_units;
  logic [1:0] mode;
  logic [2:0] count;
  logic [2:0] rtime;
  logic       finite_done;

  assign mode  = resp_q[FRC_MODE_LSB +: 2];
  assign count = resp_q[FRC_COUNT_LSB +: 3];
  assign rtime = resp_q[FRC_TIME_LSB +: 3];
  assign tmr_units = FRC_UNIT_ONE << rtime;
  assign finite_done = (count != FRC_COUNT_FOREVER) &&
                       (attempts_q >= count);

  // register port: only the response byte answers, others are refused
  always_comb begin
    resp_d = resp_q;
    rsp_d  = '0;
    if (cmd.valid) begin
      rsp_d.valid = 1'b1;
      if (cmd.code == FRC_CMD_RESPONSE) begin
        rsp_d.ack = 1'b1;
        if (cmd.write) begin
          resp_d = cmd.data;
        end
        rsp_d.data = cmd.write ? cmd.data : resp_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resp_q <= FRC_RESPONSE_RST;
      rsp_q  <= '0;
    end else begin
      resp_q <= resp_d;
      rsp_q  <= rsp_d;
    end
  end

  // retry sequencer
  always_comb begin
    state_d    = state_q;
    attempts_d = attempts_q;
    tmr_load   = 1'b0;
    restart_d  = 1'b0;
    if (!output_on_cmd || clear_fault) begin
      // off command or a clear ends any sequence and frees the latch
      state_d    = FRC_IDLE;
      attempts_d = 3'h0;
    end else begin
      unique case (state_q)
        FRC_IDLE: begin
          if (fault_in) begin
            unique case (mode)
              FRC_MODE_IGNORE: state_d = FRC_IDLE;
              FRC_MODE_RUN_DLY: begin
                state_d  = FRC_RUN_DLY;
                tmr_load = 1'b1;
              end
              FRC_MODE_RETRY: begin
                state_d  = (count == FRC_COUNT_NONE) ? FRC_LATCHED
                                                     : FRC_WAIT;
                tmr_load = (count != FRC_COUNT_NONE);
              end
              FRC_MODE_LATCH: state_d = FRC_LATCHED;
            endcase
          end
        end
        FRC_RUN_DLY: begin
          if (tmr_done) begin
            if (!fault_in) begin
              state_d = FRC_IDLE;
            end else if (count == FRC_COUNT_NONE) begin
              state_d = FRC_LATCHED;
            end else begin
              state_d  = FRC_WAIT;
              tmr_load = 1'b1;
            end
          end
        end
        FRC_WAIT: begin
          // the timer runs from one attempt start to the next
          if (tmr_done) begin
            state_d    = FRC_TRY;
            tmr_load   = 1'b1;
            restart_d  = 1'b1;
            attempts_d = (count == FRC_COUNT_FOREVER) ? attempts_q
                                                      : attempts_q + 3'h1;
          end
        end
        FRC_TRY: begin
          if (fault_in && finite_done) begin
            state_d = FRC_LATCHED;
          end else if (fault_in && tmr_done) begin
            // the next start is due now and the timer has just stopped:
            // going to wait here would hang the sequence
            state_d    = FRC_TRY;
            tmr_load   = 1'b1;
            restart_d  = 1'b1;
            attempts_d = (count == FRC_COUNT_FOREVER) ? attempts_q
                                                      : attempts_q + 3'h1;
          end else if (fault_in) begin
            state_d = FRC_WAIT;
          end else if (tmr_done) begin
            state_d    = FRC_IDLE;
            attempts_d = 3'h0;
          end
        end
        FRC_LATCHED: state_d = FRC_LATCHED;
        default:     state_d = FRC_IDLE;
      endcase
    end
    out_enable_d = output_on_cmd && !clear_fault &&
                   (state_d == FRC_IDLE || state_d == FRC_RUN_DLY ||
                    state_d == FRC_TRY);
    latched_d    = (state_d == FRC_LATCHED);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q      <= FRC_IDLE;
      attempts_q   <= 3'h0;
      out_enable_q <= 1'b0;
      restart_q    <= 1'b0;
      latched_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      attempts_q   <= attempts_d;
      out_enable_q <= out_enable_d;
      restart_q    <= restart_d;
      latched_q    <= latched_d;
    end
  end

  // unit length supplied by the separate timing-unit setting
  frc_delay_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .load       (tmr_load),
    .units      (tmr_units),
    .unit_cycles(unit_cycles),
    .done_q     (tmr_done)
  );

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_live;
    output_on_cmd && !clear_fault;
  endsequence

  sequence s_fault_seen(logic [1:0] m);
    s_live ##0 state_q == FRC_IDLE && fault_in && mode == m;
  endsequence

  a_ignore_mode: assert property (
    s_fault_seen(FRC_MODE_IGNORE) |=> state_q == FRC_IDLE && out_enable_q)
    else $error("ignored fault changed the sequence");

  a_latch_mode: assert property (
    s_fault_seen(FRC_MODE_LATCH) |=> latched_q && !out_enable_q)
    else $error("latch mode did not latch off");

  a_no_retry: assert property (
    s_fault_seen(FRC_MODE_RETRY) ##0 count == FRC_COUNT_NONE
      |=> latched_q && attempts_q == 3'h0)
    else $error("zero retry count restarted");

  a_tries_bound: assert property (
    count != FRC_COUNT_FOREVER && $stable(count) |-> attempts_q <= count
      || $past(attempts_q) == attempts_q)
    else $error("attempts exceed retry count");

  a_retry_limit: assert property (
    s_live ##0 state_q == FRC_TRY && fault_in && finite_done
      |=> latched_q ##1 (latched_q || !$past(output_on_cmd)
      || $past(clear_fault)))
    else $error("exhausted retries did not latch off");

  a_continuous: assert property (
    s_live ##0 state_q == FRC_TRY && fault_in && !tmr_done &&
      count == FRC_COUNT_FOREVER |=> state_q == FRC_WAIT && !latched_q)
    else $error("continuous retry stopped");

  a_restart_step: assert property (
    s_live ##0 state_q == FRC_WAIT && tmr_done
      |=> restart_q && out_enable_q && state_q == FRC_TRY)
    else $error("restart did not follow the retry delay");

  a_units_decode: assert property (
    tmr_load |-> $onehot(tmr_units) && tmr_units[rtime])
    else $error("delay units misdecoded");

  a_run_on: assert property (
    s_live ##0 state_q == FRC_RUN_DLY && tmr_done && !fault_in
      |=> state_q == FRC_IDLE && out_enable_q)
    else $error("run-on delay did not resume");

  a_off_clears: assert property (
    !output_on_cmd || clear_fault
      |=> state_q == FRC_IDLE && attempts_q == 3'h0 && !latched_q)
    else $error("off or clear left retry state");

  a_reg_write: assert property (
    cmd.valid && cmd.write && cmd.code == FRC_CMD_RESPONSE
      |=> rsp_q.ack && resp_q == $past(cmd.data))
    else $error("response byte write lost");

endmodule
`default_nettype wire

// ===== bench/frc_host_model.sv
// host model issuing response byte commands
`timescale 1ns/1ps
`default_nettype none
module frc_host_model import frc_pkg::*; (
  // clock
  input  wire logic     sys_clk,
  // command out, answer in
  output var frc_cmd_t  cmd,
  input  wire frc_rsp_t rsp_q
);
  initial cmd = '0;

  // one-cycle request; lines then show the inverse so stale data never
  // looks like a fresh command
  task automatic xfer(input logic w, input logic [7:0] c, d,
                      output frc_rsp_t r);
    @(negedge sys_clk);
    cmd = '{1'b1, w, c, d};
    @(negedge sys_clk);
    cmd = '{1'b0, ~w, ~c, ~d};
    if (rsp_q.valid !== 1'b1) @(negedge sys_clk);
    r = rsp_q;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// testbench of the fault retry controller
`timescale 1ns/1ps
`default_nettype none
module tb_top import frc_pkg::*;;
  logic       sys_clk, srst, fault_in, clear_fault, output_on_cmd;
  logic [15:0] unit_cycles;
  frc_cmd_t   cmd;
  frc_rsp_t   rsp_q;
  logic       out_enable_q, restart_q, latched_q;
  logic [2:0] attempts_q;
  int         err_total, checked, n, nu, rs_cnt, rs0;

  frc_fault_retry #(.UNIT_W(16)) frc_fault_retry_i (
    .sys_clk(sys_clk), .srst(srst), .cmd(cmd), .rsp_q(rsp_q),
    .fault_in(fault_in), .clear_fault(clear_fault),
    .output_on_cmd(output_on_cmd), .unit_cycles(unit_cycles),
    .out_enable_q(out_enable_q), .restart_q(restart_q),
    .latched_q(latched_q), .attempts_q(attempts_q));
  frc_host_model frc_host_model_i (
    .sys_clk(sys_clk), .cmd(cmd), .rsp_q(rsp_q));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (restart_q === 1'b1) rs_cnt++;

  task automatic wrap_up;
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rng(input string s, input int lo, hi, g);
    checked++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic reg_io(input logic w, input logic [7:0] c, d, a, e);
    frc_rsp_t r;
    frc_host_model_i.xfer(w, c, d, r);
    chk("rsp_valid", 8'h01, {7'h0, r.valid});
    chk("rsp_ack", a, {7'h0, r.ack});
    chk("rsp_data", e, r.data);
  endtask
  // bounded wait for the next restart pulse, c = cycles waited
  task automatic wait_rs(output int c);
    c = 0;
    do begin
      cyc(1);
      c++;
    end while (restart_q !== 1'b1 && c < 2000);
  endtask
  // off then on: drops any latch and starts a fresh sequence
  task automatic off_on;
    fault_in = 1'b0;
    output_on_cmd = 1'b0;
    cyc(2);
    chk("latched", 8'h00, {7'h0, latched_q});
    chk("attempts", 8'h00, {5'h0, attempts_q});
    output_on_cmd = 1'b1;
    cyc(2);
  endtask

  initial begin
    srst = 1'b1; fault_in = 1'b0; clear_fault = 1'b0;
    output_on_cmd = 1'b0; unit_cycles = 16'h0002;
    cyc(12);
    srst = 1'b0;
    chk("outs", 8'h00, {2'h0, out_enable_q, restart_q, latched_q,
                        attempts_q});
    reg_io(1'b0, FRC_CMD_RESPONSE, 8'h00, 8'h01, FRC_RESPONSE_RST);
    reg_io(1'b1, FRC_CMD_RESPONSE, 8'hc0, 8'h01, 8'hc0);
    reg_io(1'b1, 8'hc5, 8'h3c, 8'h00, 8'h00);
    reg_io(1'b0, FRC_CMD_RESPONSE, 8'h00, 8'h01, 8'hc0);
    output_on_cmd = 1'b1;
    cyc(3);
    fault_in = 1'b1;
    cyc(3);
    chk("latch_en", 8'h02, {6'h0, latched_q, out_enable_q});
    fault_in = 1'b0;
    clear_fault = 1'b1;
    cyc(1);
    clear_fault = 1'b0;
    cyc(2);
    chk("cleared", 8'h00, {7'h0, latched_q});
    reg_io(1'b1, FRC_CMD_RESPONSE, 8'h3f, 8'h01, 8'h3f);
    fault_in = 1'b1;
    cyc(8);
    chk("ignore_en", 8'h01, {7'h0, out_enable_q});
    fault_in = 1'b0;
    reg_io(1'b1, FRC_CMD_RESPONSE, 8'h80, 8'h01, 8'h80);
    rs0 = rs_cnt;
    fault_in = 1'b1;
    cyc(20);
    chk("no_retry", 8'h02, {6'h0, latched_q, out_enable_q});
    chk("no_rs", 8'h00, 8'(rs_cnt - rs0));
    off_on();
    for (int k = 1; k <= 6; k++) begin
      unit_cycles = 16'(2 + k % 2);
      nu = 2 * (2 + k % 2);
      reg_io(1'b1, FRC_CMD_RESPONSE, {2'b10, k[2:0], 3'h1}, 8'h01,
             {2'b10, k[2:0], 3'h1});
      rs0 = rs_cnt;
      fault_in = 1'b1;
      wait_rs(n);
      rng("first_start", nu + 2, nu + 4, n);
      for (int i = 2; i <= k; i++) begin
        wait_rs(n);
        rng("spacing", nu, nu + 2, n);
      end
      cyc(nu + 4);
      chk("gave_up", 8'h02, {6'h0, latched_q, out_enable_q});
      chk("attempts_n", 8'(k), {5'h0, attempts_q});
      chk("restarts_n", 8'(k), 8'(rs_cnt - rs0));
      off_on();
    end
    unit_cycles = 16'h0001;
    reg_io(1'b1, FRC_CMD_RESPONSE, 8'hb9, 8'h01, 8'hb9);
    fault_in = 1'b1;
    repeat (9) begin
      wait_rs(n);
      rng("cont_spacing", 2, 5, n);
    end
    chk("cont_latch", 8'h00, {7'h0, latched_q});
    off_on();
    unit_cycles = 16'h0003;
    reg_io(1'b1, FRC_CMD_RESPONSE, 8'h42, 8'h01, 8'h42);
    fault_in = 1'b1;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (out_enable_q === 1'b1 && n < 100);
    rng("run_on", 12, 15, n);
    cyc(2);
    chk("run_latch", 8'h01, {7'h0, latched_q});
    off_on();
    // fault gone before the run-on delay ends: output stays on
    fault_in = 1'b1;
    cyc(3);
    fault_in = 1'b0;
    cyc(14);
    chk("run_resume", 8'h01, {6'h0, latched_q, out_enable_q});
    // run on, then one retry, then give up
    reg_io(1'b1, FRC_CMD_RESPONSE, 8'h49, 8'h01, 8'h49);
    fault_in = 1'b1;
    wait_rs(n);
    rng("run_retry", 14, 17, n);
    cyc(8);
    chk("run_gave_up", 8'h02, {6'h0, latched_q, out_enable_q});
    off_on();
    wrap_up();
  end

  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
